/* include/ptc_pkg.sv */
package ptc_pkg;

  // one channel's terminal-control field, msb first
  typedef struct packed {
    logic netForceShutdown;
    logic termAConnect;
    logic wiperTermConnect;
    logic termBConnect;
  } ptc_chan_t;

  // 9-bit terminal-control register: general call accept over two channels
  typedef struct packed {
    logic         generalCallAccept;
    ptc_chan_t [1:0] chan;
  } ptc_terminal_control_reg_t;

  // switch controls handed to the analog network of one channel
  typedef struct packed {
    logic potTerminalAPin;
    logic potWiperPin;
    logic potTerminalBPin;
    logic wiperShortToB;
  } ptc_term_t;

  typedef enum logic [2:0] {
    PTC_IDLE = 3'b000,
    PTC_RECV = 3'b001,
    PTC_ACK  = 3'b010,
    PTC_SEND = 3'b011,
    PTC_MACK = 3'b100,
    PTC_SKIP = 3'b101
  } ptc_state_t;

  // reset values and wiper scale limits
  localparam logic [8:0] TERMINAL_CONTROL_REG_RESET       = 9'h1FF;
  localparam logic [8:0] WIPER_RESET      = 9'h080;
  localparam logic [8:0] WIPER_FULL_SCALE = 9'h100;
  localparam logic [8:0] WIPER_ZERO_SCALE = 9'h000;

  // slave address and special codes
  localparam logic [3:0] SLAVE_ADDR_FIXED = 4'h5;
  localparam logic [7:0] GENERAL_CALL     = 8'h00;
  localparam logic [4:0] HS_MASTER_PREFIX = 5'h01;

  // memory address field values
  localparam logic [3:0] MEM_WIPER0 = 4'h0;
  localparam logic [3:0] MEM_WIPER1 = 4'h1;
  localparam logic [3:0] MEM_TERMINAL_CONTROL_REG   = 4'h4;
  localparam logic [3:0] MEM_STATUS = 4'h5;

  // command field values
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_INC   = 2'h1;
  localparam logic [1:0] CMD_DEC   = 2'h2;
  localparam logic [1:0] CMD_READ  = 2'h3;

  // byte positions within a frame
  localparam logic [1:0] BYTE_ADDR = 2'h0;
  localparam logic [1:0] BYTE_CMD  = 2'h1;
  localparam logic [1:0] BYTE_DATA = 2'h2;

  // timing: bus clock modes in kHz and the sampling margin they leave
  localparam int CLK_SYS_KHZ  = 200000;
  localparam int STD_MODE_KHZ = 100;
  localparam int FAST_MODE_KHZ = 400;
  localparam int HS_MODE_KHZ  = 3400;
  localparam int HS_BIT_CYCLES = CLK_SYS_KHZ / HS_MODE_KHZ;
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

endpackage

/* core/ptc_sync.sv */
`timescale 1ns/1ps
module ptc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             clkEn,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1_q <= '1;
      syncOut  <= '1;
    end
    else if (clkEn)
    begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end

endmodule

/* core/pot_i2c_slave_terminal_ctrl.sv */
`timescale 1ns/1ps
module pot_i2c_slave_terminal_ctrl (
  // clock, reset, enable
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             clkEn,
  // serial bus pins; the clock pin is input only
  input  wire logic             sclIn,
  input  wire logic             sdaIn,
  output logic                  sdaOut,
  output logic                  sdaOe,
  // address and high-voltage pins
  input  wire logic             addrPinZero,
  input  wire logic             addrPinOne,
  input  wire logic             addrPinTwo,
  input  wire logic             highVoltageCmdIn,
  // status
  output logic                  hsMode,
  output logic                  highVoltageMode,
  // register contents and network controls
  output ptc_pkg::ptc_terminal_control_reg_t    terminalControlReg,
  output logic [8:0]            wiperValue0,
  output logic [8:0]            wiperValue1,
  output ptc_pkg::ptc_term_t    termCtrl0,
  output ptc_pkg::ptc_term_t    termCtrl1
);
  import ptc_pkg::*;

  logic       sclS;
  logic       sdaS;
  logic       addr0S;
  logic       addr1S;
  logic       addr2S;
  logic       hvcS;
  logic       sclPrev_q;
  logic       sdaPrev_q;
  ptc_state_t state_q;
  logic [2:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [7:0] txShift_q;
  logic       txLow_q;
  logic [1:0] byteIdx_q;
  logic       byteDone_q;
  logic       ackOk_q;
  logic       sendNext_q;
  logic       gcActive_q;
  logic       mackOk_q;
  logic [3:0] memAddr_q;
  logic       dataHi_q;
  logic       hsMode_q;
  logic       hvMode_q;
  logic       addr0_q;
  logic [1:0] capCnt_q;
  logic       capDone_q;
  ptc_terminal_control_reg_t  terminal_control_reg_q;
  logic [8:0] wiper_q [2];

  logic       sclRise;
  logic       sclFall;
  logic       startDet;
  logic       stopDet;
  logic       byteEnd;
  logic [7:0] rxByte;
  logic [6:0] devAddr;
  logic [8:0] readVal;
  logic       ackOk;
  logic       sendNext;
  logic       gcNext;
  logic       setHs;
  logic       execWr;
  logic       execInc;
  logic       execDec;
  logic [1:0] nextIdx;

  function automatic logic cmdValid(input logic [3:0] mem, input logic [1:0] cmd);
    logic ok;
    ok = 1'b0;
    if (mem == MEM_WIPER0 || mem == MEM_WIPER1)
      ok = 1'b1;
    else if (mem == MEM_TERMINAL_CONTROL_REG)
      ok = (cmd == CMD_WRITE) || (cmd == CMD_READ);
    else if (mem == MEM_STATUS)
      ok = (cmd == CMD_READ);
    return ok;
  endfunction

  // six pins synced; at 200 MHz a high-speed bit still spans dozens of samples
  ptc_sync #(.WIDTH(6)) u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .clkEn   (clkEn),
    .asyncIn ({sclIn, sdaIn, addrPinZero, addrPinOne, addrPinTwo, highVoltageCmdIn}),
    .syncOut ({sclS, sdaS, addr0S, addr1S, addr2S, hvcS})
  );

  // open drain: only ever pull low; no clock output exists at all
  assign sdaOut = 1'b0;

  assign sclRise  = sclS & ~sclPrev_q;
  assign sclFall  = ~sclS & sclPrev_q;
  assign startDet = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  assign stopDet  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
  assign rxByte   = {shift_q[6:0], sdaS};
  assign byteEnd  = (state_q == PTC_RECV) && sclRise && (bitCnt_q == 3'h7);
  // pins two and one are read live, they must stay static
  assign devAddr  = {SLAVE_ADDR_FIXED, addr2S, addr1S, addr0_q};

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end
    else if (clkEn)
    begin
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
    end
  end

  // strap capture waits for the synchroniser to fill after reset release
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      capCnt_q  <= 2'h0;
      capDone_q <= 1'b0;
      addr0_q   <= 1'b1;
    end
    else if (clkEn && !capDone_q)
    begin
      if (capCnt_q == STRAP_SETTLE_CYCLES)
      begin
        addr0_q   <= addr0S;
        capDone_q <= 1'b1;
      end
      else
        capCnt_q <= capCnt_q + 2'h1;
    end
  end

  // byte decision, evaluated at the eighth rising edge
  always_comb
  begin
    ackOk    = 1'b0;
    sendNext = 1'b0;
    gcNext   = 1'b0;
    setHs    = 1'b0;
    execWr   = 1'b0;
    execInc  = 1'b0;
    execDec  = 1'b0;
    nextIdx  = byteIdx_q;
    unique case (byteIdx_q)
      BYTE_ADDR:
      begin
        nextIdx = BYTE_CMD;
        if (rxByte[7:1] == devAddr)
        begin
          ackOk    = 1'b1;
          sendNext = rxByte[0];
        end
        else if (rxByte == GENERAL_CALL && terminal_control_reg_q.generalCallAccept)
        begin
          ackOk  = 1'b1;
          gcNext = 1'b1;
        end
        else if (rxByte[7:3] == HS_MASTER_PREFIX)
          setHs = 1'b1;
      end
      BYTE_CMD:
      begin
        // general call command table is not decoded: refused
        if (!gcActive_q && cmdValid(rxByte[7:4], rxByte[3:2]))
        begin
          ackOk = 1'b1;
          unique case (rxByte[3:2])
            CMD_WRITE: nextIdx  = BYTE_DATA;
            CMD_INC:   execInc  = 1'b1;
            CMD_DEC:   execDec  = 1'b1;
            CMD_READ:  sendNext = 1'b1;
          endcase
        end
      end
      BYTE_DATA:
      begin
        ackOk   = 1'b1;
        execWr  = 1'b1;
        nextIdx = BYTE_CMD;
      end
      default:
        ackOk = 1'b0;
    endcase
  end

  always_comb
  begin
    unique case (memAddr_q)
      MEM_WIPER0: readVal = wiper_q[0];
      MEM_WIPER1: readVal = wiper_q[1];
      MEM_TERMINAL_CONTROL_REG:   readVal = terminal_control_reg_q;
      default:    readVal = {7'h00, hsMode_q, hvMode_q};
    endcase
  end

  // bus state machine; start and stop win over any bit event
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q    <= PTC_IDLE;
      bitCnt_q   <= 3'h0;
      shift_q    <= 8'h00;
      txShift_q  <= 8'h00;
      txLow_q    <= 1'b0;
      byteIdx_q  <= BYTE_ADDR;
      byteDone_q <= 1'b0;
      ackOk_q    <= 1'b0;
      sendNext_q <= 1'b0;
      gcActive_q <= 1'b0;
      mackOk_q   <= 1'b0;
      memAddr_q  <= MEM_WIPER0;
      dataHi_q   <= 1'b0;
      sdaOe      <= 1'b0;
    end
    else if (clkEn)
    begin
      if (startDet)
      begin
        state_q    <= PTC_RECV;
        bitCnt_q   <= 3'h0;
        byteIdx_q  <= BYTE_ADDR;
        byteDone_q <= 1'b0;
        gcActive_q <= 1'b0;
        sdaOe      <= 1'b0;
      end
      else if (stopDet)
      begin
        state_q    <= PTC_IDLE;
        byteDone_q <= 1'b0;
        sdaOe      <= 1'b0;
      end
      else
      begin
        unique case (state_q)
          PTC_IDLE, PTC_SKIP:
            sdaOe <= 1'b0;
          PTC_RECV:
          begin
            if (sclRise)
            begin
              shift_q  <= rxByte;
              bitCnt_q <= bitCnt_q + 3'h1;
              if (bitCnt_q == 3'h7)
              begin
                byteDone_q <= 1'b1;
                ackOk_q    <= ackOk;
                sendNext_q <= sendNext;
                byteIdx_q  <= nextIdx;
                if (gcNext)
                  gcActive_q <= 1'b1;
                if (byteIdx_q == BYTE_CMD && ackOk)
                begin
                  memAddr_q <= rxByte[7:4];
                  dataHi_q  <= rxByte[0];
                end
              end
            end
            else if (sclFall && byteDone_q)
            begin
              state_q    <= PTC_ACK;
              byteDone_q <= 1'b0;
              sdaOe      <= ackOk_q;
            end
          end
          PTC_ACK:
          begin
            if (sclFall)
            begin
              bitCnt_q <= 3'h0;
              if (!ackOk_q)
              begin
                state_q <= PTC_SKIP;
                sdaOe   <= 1'b0;
              end
              else if (sendNext_q)
              begin
                state_q   <= PTC_SEND;
                txLow_q   <= 1'b1;
                txShift_q <= {7'h00, readVal[8]};
                sdaOe     <= 1'b1;
              end
              else
              begin
                state_q <= PTC_RECV;
                sdaOe   <= 1'b0;
              end
            end
          end
          PTC_SEND:
          begin
            if (sclFall)
            begin
              if (bitCnt_q == 3'h7)
              begin
                state_q <= PTC_MACK;
                sdaOe   <= 1'b0;
              end
              else
              begin
                bitCnt_q  <= bitCnt_q + 3'h1;
                txShift_q <= {txShift_q[6:0], 1'b0};
                sdaOe     <= ~txShift_q[6];
              end
            end
          end
          PTC_MACK:
          begin
            if (sclRise)
              mackOk_q <= ~sdaS;
            else if (sclFall)
            begin
              bitCnt_q <= 3'h0;
              if (mackOk_q)
              begin
                state_q   <= PTC_SEND;
                txLow_q   <= ~txLow_q;
                txShift_q <= txLow_q ? readVal[7:0] : {7'h00, readVal[8]};
                sdaOe     <= txLow_q ? ~readVal[7] : 1'b1;
              end
              else
                state_q <= PTC_SKIP;
            end
          end
          default:
            state_q <= PTC_IDLE;
        endcase
      end
    end
  end

  // high-speed mode and high-voltage marking live until the next stop
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hsMode_q <= 1'b0;
      hvMode_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (stopDet)
      begin
        hsMode_q <= 1'b0;
        hvMode_q <= 1'b0;
      end
      else if (byteEnd && byteIdx_q == BYTE_ADDR)
      begin
        if (setHs)
          hsMode_q <= 1'b1;
        if (hvcS)
          hvMode_q <= 1'b1;
      end
    end
  end

  // register updates; shutdown state never gates these writes
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      terminal_control_reg_q     <= TERMINAL_CONTROL_REG_RESET;
      wiper_q[0] <= WIPER_RESET;
      wiper_q[1] <= WIPER_RESET;
    end
    else if (clkEn && byteEnd && !gcActive_q)
    begin
      if (execWr && memAddr_q == MEM_TERMINAL_CONTROL_REG)
        terminal_control_reg_q <= {dataHi_q, rxByte};
      else if (execWr && memAddr_q[3:1] == 3'h0)
        wiper_q[memAddr_q[0]] <= {dataHi_q, rxByte};
      else if (execInc && wiper_q[rxByte[4]] < WIPER_FULL_SCALE)
        wiper_q[rxByte[4]] <= wiper_q[rxByte[4]] + 9'h001;
      else if (execDec && wiper_q[rxByte[4]] != WIPER_ZERO_SCALE)
        wiper_q[rxByte[4]] <= wiper_q[rxByte[4]] - 9'h001;
    end
  end

  // wiper registers are independent of shutdown, so exit restores position
  assign wiperValue0        = wiper_q[0];
  assign wiperValue1        = wiper_q[1];
  assign terminalControlReg = terminal_control_reg_q;
  assign hsMode             = hsMode_q;
  assign highVoltageMode    = hvMode_q;

  // connect bits are overridden, not cleared, so they return intact
  always_comb
  begin
    termCtrl0.potTerminalAPin = terminal_control_reg_q.chan[0].netForceShutdown & terminal_control_reg_q.chan[0].termAConnect;
    termCtrl0.potWiperPin     = ~terminal_control_reg_q.chan[0].netForceShutdown | terminal_control_reg_q.chan[0].wiperTermConnect;
    termCtrl0.potTerminalBPin = ~terminal_control_reg_q.chan[0].netForceShutdown | terminal_control_reg_q.chan[0].termBConnect;
    termCtrl0.wiperShortToB   = ~terminal_control_reg_q.chan[0].netForceShutdown;
    termCtrl1.potTerminalAPin = terminal_control_reg_q.chan[1].netForceShutdown & terminal_control_reg_q.chan[1].termAConnect;
    termCtrl1.potWiperPin     = ~terminal_control_reg_q.chan[1].netForceShutdown | terminal_control_reg_q.chan[1].wiperTermConnect;
    termCtrl1.potTerminalBPin = ~terminal_control_reg_q.chan[1].netForceShutdown | terminal_control_reg_q.chan[1].termBConnect;
    termCtrl1.wiperShortToB   = ~terminal_control_reg_q.chan[1].netForceShutdown;
  end

endmodule

/* test/ptc_i2c_master.sv */
`timescale 1ns/1ps
module ptc_i2c_master (
  // bus clock and data pull-down; clock stands high between frames
  output logic      sclLine,
  output logic      sdaLow,
  // wired-and level of the data line
  input  wire logic sdaLine
);
  initial
  begin
    sclLine = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic start();
    sdaLow = 1'b0;
    #16 sclLine = 1'b1;
    #16 sdaLow = 1'b1;
    #16 sclLine = 1'b0;
  endtask

  task automatic stop();
    sdaLow = 1'b1;
    #16 sclLine = 1'b1;
    #16 sdaLow = 1'b0;
    #32;
  endtask

  // data moves only in the low half of the clock
  task automatic bitIo(input logic b, output logic s);
    sdaLow = !b;
    #16 sclLine = 1'b1;
    #16 s = sdaLine;
    #16 sclLine = 1'b0;
    #16;
  endtask

  task automatic wrByte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitIo(v[i], s);
    bitIo(1'b1, s);
    ack = !s;
  endtask

  task automatic rdByte(input logic mack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bitIo(1'b1, s);
      v[i] = s;
    end
    bitIo(!mack, s);
  endtask
endmodule

/* test/ptc_asserts.sv */
`timescale 1ns/1ps
module ptc_asserts (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               reset_n,
  // bus pins
  input wire logic               sclIn,
  input wire logic               sdaIn,
  input wire logic               sdaOe,
  // status and controls
  input wire logic               hsMode,
  input wire logic               highVoltageMode,
  input wire ptc_pkg::ptc_terminal_control_reg_t terminalControlReg,
  input wire logic [8:0]         wiperValue0,
  input wire logic [8:0]         wiperValue1,
  input wire ptc_pkg::ptc_term_t termCtrl0,
  input wire ptc_pkg::ptc_term_t termCtrl1
);
  import ptc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence stopSeen;
    sclIn && $rose(sdaIn);
  endsequence
  sequence ackOn;
    $rose(sdaOe);
  endsequence
  sequence ackHeld;
    sdaOe [*8];
  endsequence

  chk_shut_term: assert property (!terminalControlReg.chan[0].netForceShutdown |-> !termCtrl0.potTerminalAPin
    && termCtrl0.wiperShortToB) else $error("shutdown terminals wrong on pot 0");
  chk_shut_pot1: assert property (!terminalControlReg.chan[1].netForceShutdown |-> !termCtrl1.potTerminalAPin
    && termCtrl1.wiperShortToB) else $error("shutdown terminals wrong on pot 1");
  chk_conn_follow: assert property (terminalControlReg.chan[0].netForceShutdown |-> termCtrl0 ==
    {terminalControlReg.chan[0][2:0], 1'b0}) else $error("terminal outputs differ from control bits");
  chk_wiper_keep: assert property ($changed(terminalControlReg) |-> $stable(wiperValue0)
    && $stable(wiperValue1)) else $error("wiper moved with terminal control");
  chk_terminal_control_reg_rise: assert property ($changed(terminalControlReg) |-> sclIn)
    else $error("terminal control changed outside clock high");
  chk_sda_scl_low: assert property (($rose(sdaOe) || $fell(sdaOe)) |-> !sclIn)
    else $error("data line moved while clock high");
  chk_ack_hold: assert property (ackOn |-> ackHeld)
    else $error("acknowledge too short");
  chk_stop_idle: assert property (stopSeen |-> ##[1:8] (!hsMode && !highVoltageMode))
    else $error("stop did not clear modes");
  chk_terminal_control_reg_reset: assert property ($rose(reset_n) |-> terminalControlReg == TERMINAL_CONTROL_REG_RESET
    && wiperValue0 == WIPER_RESET) else $error("reset values wrong");
endmodule

bind pot_i2c_slave_terminal_ctrl ptc_asserts i_ptc_asserts (
  .clk_sys            (clk_sys),
  .reset_n            (reset_n),
  .sclIn              (sclIn),
  .sdaIn              (sdaIn),
  .sdaOe              (sdaOe),
  .hsMode             (hsMode),
  .highVoltageMode    (highVoltageMode),
  .terminalControlReg (terminalControlReg),
  .wiperValue0        (wiperValue0),
  .wiperValue1        (wiperValue1),
  .termCtrl0          (termCtrl0),
  .termCtrl1          (termCtrl1)
);

/* test/pot_i2c_slave_terminal_ctrl_tb.sv */
`timescale 1ns/1ps
module pot_i2c_slave_terminal_ctrl_tb;
  import ptc_pkg::*;
  logic               clk_sys = 1'b0;
  logic               reset_n = 1'b0;
  logic               addrPinZero = 1'b1;
  logic               highVoltageCmdIn = 1'b0;
  logic               sclIn, sdaIn, sdaLow, sdaOut, sdaOe, hsMode, highVoltageMode;
  ptc_terminal_control_reg_t          terminalControlReg;
  logic [8:0]         wiperValue0, wiperValue1;
  ptc_term_t          termCtrl0, termCtrl1;
  int                 error_cnt = 0;
  int                 num_checks = 0;
  // {terminal_control_reg, termCtrl0, termCtrl1}
  localparam logic [16:0] ROWS [7] = '{{9'h1FF, 4'hE, 4'hE}, {9'h1F7, 4'h7, 4'hE}, {9'h17F, 4'hE, 4'h7},
    {9'h1A5, 4'h7, 4'h4}, {9'h1F0, 4'h7, 4'hE}, {9'h1F8, 4'h0, 4'hE}, {9'h0D0, 4'h7, 4'hA}};
  // {address, command, acks}
  localparam logic [18:0] BADS [5] = '{{8'h5C, 8'h00, 3'b000}, {8'h50, 8'h00, 3'b000},
    {8'h5E, 8'h20, 3'b100}, {8'h5E, 8'h44, 3'b100}, {8'h5E, 8'h50, 3'b100}};

  // pull-up on the data line, either party pulls it low
  assign sdaIn = !(sdaLow || (sdaOe && !sdaOut));

  pot_i2c_slave_terminal_ctrl i_pot_i2c_slave_terminal_ctrl (
    .clk_sys(clk_sys), .reset_n(reset_n), .clkEn(1'b1), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .addrPinZero(addrPinZero), .addrPinOne(1'b1), .addrPinTwo(1'b1),
    .highVoltageCmdIn(highVoltageCmdIn), .hsMode(hsMode), .highVoltageMode(highVoltageMode),
    .terminalControlReg(terminalControlReg), .wiperValue0(wiperValue0), .wiperValue1(wiperValue1),
    .termCtrl0(termCtrl0), .termCtrl1(termCtrl1));

  ptc_i2c_master i_ptc_i2c_master (.sclLine(sclIn), .sdaLow(sdaLow), .sdaLine(sdaIn));

  always #2.5 clk_sys = ~clk_sys;

  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d, input logic [2:0] ea);
    logic [2:0] k;
    i_ptc_i2c_master.start();
    i_ptc_i2c_master.wrByte(a, k[2]);
    i_ptc_i2c_master.wrByte(c, k[1]);
    i_ptc_i2c_master.wrByte(d, k[0]);
    i_ptc_i2c_master.stop();
    chk("ack", 9'(ea), 9'(k));
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard, far above the longest sequence
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    $display("BAD watchdog expected done seen timeout");
    test_done();
  end

  initial
  begin
    logic       k;
    logic [7:0] d0, d1;
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (12) @(negedge clk_sys);
    xfer(8'h5E, 8'h00, 8'hC3, 3'b111);
    for (int r = 0; r < 7; r++)
    begin
      xfer(8'h5E, {7'h20, ROWS[r][16]}, ROWS[r][15:8], 3'b111);
      chk("terminal_control_reg", ROWS[r][16:8], terminalControlReg);
      chk("term0", 9'(ROWS[r][7:4]), 9'(termCtrl0));
      chk("term1", 9'(ROWS[r][3:0]), 9'(termCtrl1));
      chk("wiper0", 9'h0C3, wiperValue0);
    end
    $display("test rows done");
    xfer(8'h00, 8'h00, 8'h00, 3'b000);
    xfer(8'h5E, 8'h01, 8'h00, 3'b111);
    chk("wiper0", 9'h100, wiperValue0);
    i_ptc_i2c_master.start();
    i_ptc_i2c_master.wrByte(8'h5F, k);
    i_ptc_i2c_master.rdByte(1'b1, d0);
    i_ptc_i2c_master.rdByte(1'b0, d1);
    i_ptc_i2c_master.stop();
    chk("rdack", 9'h001, 9'(k));
    chk("rdhi", 9'h001, 9'(d0));
    chk("rdlo", 9'h000, 9'(d1));
    // wiper 0 is at full scale, so its increment must saturate
    xfer(8'h5E, 8'h04, 8'h14, 3'b111);
    chk("wiper0", 9'h100, wiperValue0);
    chk("wiper1", 9'h081, wiperValue1);
    xfer(8'h5E, 8'h18, 8'h18, 3'b111);
    chk("wiper1", 9'h07F, wiperValue1);
    $display("test shutdown access done");
    @(negedge clk_sys);
    addrPinZero = 1'b0;
    xfer(8'h5E, 8'h41, 8'hF0, 3'b111);
    xfer(8'h00, 8'h00, 8'h00, 3'b100);
    for (int i = 0; i < 5; i++)
      xfer(BADS[i][18:11], BADS[i][10:3], 8'h00, BADS[i][2:0]);
    $display("test refusals done");
    i_ptc_i2c_master.start();
    i_ptc_i2c_master.wrByte(8'h08, k);
    chk("hsack", 9'h000, 9'(k));
    chk("hs", 9'h001, 9'(hsMode));
    i_ptc_i2c_master.start();
    i_ptc_i2c_master.wrByte(8'h5E, k);
    chk("hsaddr", 9'h001, 9'(k));
    i_ptc_i2c_master.stop();
    chk("hsoff", 9'h000, 9'(hsMode));
    @(negedge clk_sys);
    highVoltageCmdIn = 1'b1;
    i_ptc_i2c_master.start();
    i_ptc_i2c_master.wrByte(8'h5E, k);
    chk("hv", 9'h001, 9'(highVoltageMode));
    i_ptc_i2c_master.wrByte(8'h5C, k);
    chk("stack", 9'h001, 9'(k));
    i_ptc_i2c_master.rdByte(1'b1, d0);
    i_ptc_i2c_master.rdByte(1'b0, d1);
    chk("sthi", 9'h000, 9'(d0));
    chk("stlo", 9'h001, 9'(d1));
    @(negedge clk_sys);
    highVoltageCmdIn = 1'b0;
    i_ptc_i2c_master.stop();
    chk("hvoff", 9'h000, 9'(highVoltageMode));
    $display("test modes done");
    @(negedge clk_sys);
    // pin zero stays low, so only a fresh capture can match below
    reset_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    chk("terminal_control_reg", 9'h1FF, terminalControlReg);
    chk("wiper0", 9'h080, wiperValue0);
    chk("wiper1", 9'h080, wiperValue1);
    chk("term0", 9'h00E, 9'(termCtrl0));
    repeat (12) @(negedge clk_sys);
    xfer(8'h5C, 8'h41, 8'hFF, 3'b111);
    $display("test reset done");
    test_done();
  end
endmodule
